/* File: pkg/sam_regs.svh */
// constants for the serial converter control block
// assumes inclusion by bare name from design and testbench files
`ifndef SAM_REGS_SVH
`define SAM_REGS_SVH
`define SAM_RES_BITS      8
`define SAM_WORD_8CH      4
`define SAM_WORD_4CH      3
`define SAM_CLK_PERIOD_NS 10
`define SAM_SCLK_NS       4000
`define SAM_SCLK_DIV      (`SAM_SCLK_NS / (2 * `SAM_CLK_PERIOD_NS))
`define SAM_OFS_CTRL      32'h0000_0000
`define SAM_OFS_STATUS    32'h0000_0004
`define SAM_OFS_RESULT    32'h0000_0008
`define SAM_OFS_CFG       32'h0000_000c
`define SAM_CTRL_GO       0
`define SAM_ST_BUSY       0
`define SAM_ST_DONE       1
`endif

/* File: pkg/sam_pkg.sv */
// types shared by both ends of the serial converter link
// assumes sam_regs.svh on the include path
package sam_pkg;
  typedef enum logic [2:0] {
    SAM_IDLE   = 3'b000,
    SAM_ADDR   = 3'b001,
    SAM_SETTLE = 3'b011,
    SAM_MSB    = 3'b010,
    SAM_LSB    = 3'b110,
    SAM_HOLD   = 3'b111
  } sam_dev_state_t;
  typedef enum logic [2:0] {
    SAM_H_IDLE = 3'b000,
    SAM_H_SEL  = 3'b001,
    SAM_H_RUN  = 3'b011,
    SAM_H_END  = 3'b010
  } sam_host_state_t;
endpackage

/* File: pkg/sam_if.sv */
// link between converter device and controller
// assumes one shared clock, sclk is a plain data level
interface sam_if;
  logic cs_n;
  logic sclk;
  logic serial_address_in;
  logic dout;
  logic dout_oe_n;
  logic conversion_active_flag;
  logic lsb_order_enable_n;
  modport dev (input cs_n, sclk, serial_address_in, lsb_order_enable_n,
               output dout, dout_oe_n, conversion_active_flag);
  modport host (output cs_n, sclk, serial_address_in, lsb_order_enable_n,
                input dout, dout_oe_n, conversion_active_flag);
endinterface

/* File: design/sam_sync3.sv */
// three-stage synchroniser with agreement filter
// assumes inputs asynchronous to clk
module sam_sync3
  import sam_pkg::*;
#(
  parameter bit RST_VAL = 1'b0
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // level
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       q_reg;
  logic       q_next;
  always_comb
  begin
    sh_next = {sh_reg[1:0], din};
    q_next  = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sh_reg <= {3{RST_VAL}};
      q_reg  <= RST_VAL;
    end
    else
    begin
      sh_reg <= sh_next;
      q_reg  <= q_next;
    end
  end
  assign dout = q_reg;
endmodule // sam_sync3

/* File: design/sam_device.sv */
// converter device end: address shifting, sequencing, serial result
// assumes sampled link pins; comparator replaced by a digital sample
//
// Contract
// R01: chip select low enables the logic
// R02: chip select held low throughout
// R03: sample address input on rising clock
// R04: first high after select is start
// R05: assignment word follows start bit
// R06: start reaching position latches channel, converts
// R07: busy flag high, address input ignored
// R08: one settling period driving low
// R09: result bits out MSB first
// R10: eight periods then busy low
// R11: four-input part repeats result LSB first
// R12: enable high holds LSB static
// R13: enable low shifts register LSB first
// R14: chip select high clears, output released
// R15: new select edge per conversion
// R16: address sampled only while output released
// R17: negative difference gives zero code
// R18: word decodes inputs, mode, polarity
// R19: differential pairs are adjacent even/odd
// R20: single-ended eight-input uses common negative
// R21: four-input fixes pair bit0 high
// R22: four-input decode table
// R23: eight-input decode table
// R24: output changes after falling edge
`include "sam_regs.svh"
module sam_device
  import sam_pkg::*;
#(
  parameter bit EIGHT_CH = 1'b1
)
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // link
  sam_if.dev                          lnk,
  // analog stand-in: one code per channel, plus common
  input  wire logic [8*`SAM_RES_BITS-1:0] ch_code,
  input  wire logic [`SAM_RES_BITS-1:0]   com_code,
  // decode observed
  output logic [7:0]                  pos_sel,
  output logic [8:0]                  neg_sel
);
  logic cs_n_s;
  logic sclk_s;
  logic di_s;
  logic se_n_s;
  // idle level of chip select is high, so no false select after reset
  sam_sync3 #(.RST_VAL(1'b1)) u_cs (.clk(clk), .srst(srst), .din(lnk.cs_n), .dout(cs_n_s));
  sam_sync3 u_ck (.clk(clk), .srst(srst), .din(lnk.sclk), .dout(sclk_s));
  sam_sync3 u_di (.clk(clk), .srst(srst), .din(lnk.serial_address_in), .dout(di_s));
  sam_sync3 u_se (.clk(clk), .srst(srst), .din(lnk.lsb_order_enable_n), .dout(se_n_s));

  sam_dev_state_t      st_reg, st_next;
  logic                ck_d_reg, ck_d_next;
  logic [4:0]          sh_reg, sh_next;
  logic [3:0]          cnt_reg, cnt_next;
  logic [8:0]          res_reg, res_next;
  logic                do_reg, do_next;
  logic                oe_n_reg, oe_n_next;
  logic [7:0]          pos_reg, pos_next;
  logic [8:0]          neg_reg, neg_next;
  logic [`SAM_RES_BITS-1:0] code_reg, code_next;
  logic                rise;
  logic                fall;
  logic                start_hit;
  logic [3:0]          word;
  logic                sgl;
  logic                odd;
  logic [1:0]          pidx;
  logic [2:0]          pch;
  logic [2:0]          nch;
  logic [`SAM_RES_BITS-1:0] vp;
  logic [`SAM_RES_BITS-1:0] vn;

  assign rise = sclk_s & ~ck_d_reg;
  assign fall = ~sclk_s & ck_d_reg;
  // start bit lands at bit 4 of the address register, bit 3 on the four-input part
  assign start_hit = EIGHT_CH ? sh_reg[4] : sh_reg[3]; // R06
  assign word = EIGHT_CH ? sh_reg[3:0] : {sh_reg[2:0], 1'b1}; // R21

  always_comb
  begin
    sgl  = word[3];
    odd  = word[2];
    pidx = EIGHT_CH ? word[1:0] : {1'b0, word[1]}; // R22
    pch  = {pidx, odd}; // R18 R22 R23
    nch  = {pidx, ~odd}; // R19
    pos_next = 8'h00;
    neg_next = 9'h000;
    pos_next[pch] = 1'b1;
    if (!sgl)
      neg_next[nch] = 1'b1;
    else if (EIGHT_CH)
      neg_next[8] = 1'b1; // R20
    vp = ch_code[pch*`SAM_RES_BITS +: `SAM_RES_BITS];
    if (!sgl)
      vn = ch_code[nch*`SAM_RES_BITS +: `SAM_RES_BITS];
    else if (EIGHT_CH)
      vn = com_code;
    else
      vn = '0;
    code_next = (vp < vn) ? '0 : vp - vn; // R17
  end

  always_comb
  begin
    st_next   = st_reg;
    ck_d_next = sclk_s;
    sh_next   = sh_reg;
    cnt_next  = cnt_reg;
    res_next  = res_reg;
    do_next   = do_reg;
    oe_n_next = oe_n_reg;
    if (cs_n_s)
    begin
      st_next   = SAM_IDLE; // R14
      sh_next   = 5'h00;
      cnt_next  = 4'h0;
      res_next  = 9'h000;
      do_next   = 1'b0;
      oe_n_next = 1'b1;
    end
    else
    begin
      unique case (st_reg)
        SAM_IDLE:
          st_next = SAM_ADDR; // R01 R15
        SAM_ADDR:
          if (start_hit)
          begin
            st_next  = SAM_SETTLE; // R06
            cnt_next = 4'h0;
          end
          else if (rise && (sh_reg != 5'h00 || di_s))
            sh_next = {sh_reg[3:0], di_s}; // R03 R04 R16
        SAM_SETTLE:
          if (fall)
          begin
            oe_n_next = 1'b0; // R08 R24
            do_next   = 1'b0;
            st_next   = SAM_MSB;
          end
        SAM_MSB:
          if (fall)
          begin
            if (cnt_reg == 4'(`SAM_RES_BITS))
            begin
              st_next  = SAM_LSB; // R10
              cnt_next = 4'h1;
              do_next  = res_reg[0]; // R11 R12
            end
            else
            begin
              do_next  = code_reg[`SAM_RES_BITS-1-cnt_reg[2:0]]; // R09
              res_next = {res_reg[7:0], code_reg[`SAM_RES_BITS-1-cnt_reg[2:0]]};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        SAM_LSB:
          if (fall && (!EIGHT_CH || !se_n_s)) // R11 R12 R13
          begin
            if (cnt_reg == 4'(`SAM_RES_BITS))
              st_next = SAM_HOLD;
            else
            begin
              do_next  = res_reg[cnt_reg];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        SAM_HOLD:
          st_next = SAM_HOLD;
        default:
          st_next = SAM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg   <= SAM_IDLE;
      ck_d_reg <= 1'b0;
      sh_reg   <= 5'h00;
      cnt_reg  <= 4'h0;
      res_reg  <= 9'h000;
      do_reg   <= 1'b0;
      oe_n_reg <= 1'b1;
      pos_reg  <= 8'h00;
      neg_reg  <= 9'h000;
      code_reg <= '0;
    end
    else
    begin
      st_reg   <= st_next;
      ck_d_reg <= ck_d_next;
      sh_reg   <= sh_next;
      cnt_reg  <= cnt_next;
      res_reg  <= res_next;
      do_reg   <= do_next;
      oe_n_reg <= oe_n_next;
      if (st_reg == SAM_ADDR && start_hit)
      begin
        pos_reg  <= pos_next; // R06
        neg_reg  <= neg_next;
        code_reg <= code_next;
      end
    end
  end

  assign lnk.dout      = do_reg;
  assign lnk.dout_oe_n = oe_n_reg;
  // busy from channel latch (start bit at bit 4 of address register, bit 3 on four-input) until the eighth bit
  assign lnk.conversion_active_flag = (st_reg == SAM_SETTLE) || (st_reg == SAM_MSB); // R07 R10
  assign pos_sel = pos_reg;
  assign neg_sel = neg_reg;
endmodule // sam_device

/* File: design/sam_host.sv */
// controller end: APB-programmed conversion over the serial link
// assumes one clk for APB and link; device answers on the shared bus
`include "sam_regs.svh"
module sam_host
  import sam_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  sam_if.host              lnk
);
  sam_host_state_t st_reg, st_next;
  logic [4:0]  cfg_reg, cfg_next;
  logic [15:0] div_reg, div_next;
  logic        ck_reg, ck_next;
  logic [5:0]  bit_reg, bit_next;
  logic [16:0] rx_reg, rx_next;
  logic        done_reg, done_next;
  logic        cs_reg, cs_next;
  logic        di_reg, di_next;
  logic [5:0]  tx_len;
  logic [4:0]  tx_word;
  logic        tick;
  logic        wr;
  logic        go;

  assign wr = psel & penable & pwrite;
  assign go = wr && paddr == `SAM_OFS_CTRL && pwdata[`SAM_CTRL_GO];
  assign tick = div_reg == 16'(`SAM_SCLK_DIV - 1);
  // start bit, then config word
  assign tx_word = {1'b1, cfg_reg[3:0]};
  // index from zero of the last bit: start, word, settle, msb 8, lsb 8
  assign tx_len = cfg_reg[4] ? 6'd4 + 6'd1 + 6'd8 + 6'd8 : 6'd3 + 6'd1 + 6'd8 + 6'd8; // R05

  always_comb
  begin
    st_next   = st_reg;
    cfg_next  = cfg_reg;
    div_next  = tick ? 16'h0000 : div_reg + 16'h0001;
    ck_next   = ck_reg;
    bit_next  = bit_reg;
    rx_next   = rx_reg;
    done_next = done_reg;
    cs_next   = cs_reg;
    di_next   = di_reg;
    if (wr && paddr == `SAM_OFS_CFG && st_reg == SAM_H_IDLE)
      cfg_next = pwdata[4:0];
    if (wr && paddr == `SAM_OFS_STATUS && pwdata[`SAM_ST_DONE])
      done_next = 1'b0;
    unique case (st_reg)
      SAM_H_IDLE:
        if (go)
        begin
          cs_next   = 1'b0; // R01 R15
          ck_next   = 1'b0;
          bit_next  = 6'h00;
          rx_next   = 17'h00000;
          div_next  = 16'h0000;
          di_next   = tx_word[4];
          st_next   = SAM_H_SEL;
        end
      SAM_H_SEL:
        if (tick)
          st_next = SAM_H_RUN;
      SAM_H_RUN:
        if (tick)
        begin
          ck_next = ~ck_reg;
          if (!ck_reg)
          begin
            if (lnk.dout_oe_n == 1'b0)
              rx_next = {rx_reg[15:0], lnk.dout};
          end
          else
          begin
            bit_next = bit_reg + 6'h01;
            if (bit_reg < (cfg_reg[4] ? 6'd4 : 6'd3))
              di_next = tx_word[3'(3 - bit_reg)]; // R05
            else
              di_next = 1'b0; // R16
            if (bit_reg == tx_len)
              st_next = SAM_H_END;
          end
        end
      SAM_H_END:
        if (tick)
        begin
          cs_next   = 1'b1; // R02 R14
          done_next = 1'b1;
          st_next   = SAM_H_IDLE;
        end
      default:
        st_next = SAM_H_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg   <= SAM_H_IDLE;
      cfg_reg  <= 5'h10;
      div_reg  <= 16'h0000;
      ck_reg   <= 1'b0;
      bit_reg  <= 6'h00;
      rx_reg   <= 17'h00000;
      done_reg <= 1'b0;
      cs_reg   <= 1'b1;
      di_reg   <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      cfg_reg  <= cfg_next;
      div_reg  <= div_next;
      ck_reg   <= ck_next;
      bit_reg  <= bit_next;
      rx_reg   <= rx_next;
      done_reg <= done_next;
      cs_reg   <= cs_next;
      di_reg   <= di_next;
    end
  end

  always_comb
  begin
    unique case (paddr)
      `SAM_OFS_STATUS: prdata = {30'h0, done_reg, st_reg != SAM_H_IDLE};
      `SAM_OFS_RESULT: prdata = {15'h0, rx_reg};
      `SAM_OFS_CFG:    prdata = {27'h0, cfg_reg};
      default:         prdata = 32'h0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr[31:4] != 28'h0 || paddr[1:0] != 2'h0);
  assign lnk.cs_n = cs_reg;
  assign lnk.sclk = ck_reg;
  assign lnk.serial_address_in = di_reg;
  // 8-channel part: drop to start LSB-first readout at once
  assign lnk.lsb_order_enable_n = 1'b0; // R13
endmodule // sam_host

/* File: tb/sam_link_monitor.sv */
// link checker: timing relations between the two ends
// assumes one clk for both ends, srst synchronous active high
`include "sam_regs.svh"
module sam_link_monitor
  import sam_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_address_in,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic conversion_active_flag,
  input wire logic lsb_order_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPAN_LO = 16 * `SAM_SCLK_DIV;
  localparam int SPAN_HI = 20 * `SAM_SCLK_DIV;
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;

  // busy length counter
  always_comb busy_cnt_next = conversion_active_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
  always_ff @(posedge clk) busy_cnt_reg <= srst ? 16'h0000 : busy_cnt_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_busy_up;
    $rose(conversion_active_flag);
  endsequence
  sequence s_busy_down;
    $fell(conversion_active_flag) && !cs_n;
  endsequence
  sequence s_drive_on;
    $fell(dout_oe_n);
  endsequence

  a_release_idle: assert property ($rose(cs_n) |-> ##[1:6] dout_oe_n)
    else $error("output not released after deselect");
  a_idle_no_busy: assert property (cs_n [*6] |-> !conversion_active_flag)
    else $error("busy while deselected");
  a_start_on_rise: assert property (s_busy_up |-> sclk)
    else $error("busy rose away from a rising link clock");
  a_settle_low: assert property (s_drive_on |-> conversion_active_flag && !dout)
    else $error("settle period not low or not busy");
  a_change_on_fall: assert property ($changed(dout) && !dout_oe_n |-> !sclk)
    else $error("result bit changed while link clock high");
  a_select_for_drive: assert property (!dout_oe_n |-> !$past(cs_n, 8))
    else $error("output driven while deselected");
  a_busy_span: assert property (s_busy_down |-> busy_cnt_reg >= SPAN_LO && busy_cnt_reg <= SPAN_HI)
    else $error("busy length wrong");
  a_end_on_fall: assert property (s_busy_down |-> !sclk)
    else $error("busy fell while link clock high");
endmodule // sam_link_monitor

/* File: tb/serial_adc_mux_control_test.sv */
// self-checking bench: controller and device joined over the link
// assumes design files and sam_regs.svh on the include path
`include "sam_regs.svh"
module serial_adc_mux_control_test
  import sam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [2:0] kind; logic [31:0] val; } sam_note_t;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, rd_chk, busy_d;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [63:0] ch_code;
  logic [7:0]  com_code, pos_sel;
  logic [8:0]  neg_sel;
  logic [3:0]  tbl [0:4] = '{4'h8, 4'h0, 4'h7, 4'hf, 4'h5};
  int          n_mismatch, compares;
  sam_note_t   note_q[$];
  sam_note_t   nt;

  sam_if link();
  sam_host u_sam_host (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(link));
  sam_device #(.EIGHT_CH(1'b1)) u_sam_device (.clk(clk), .srst(srst), .lnk(link),
    .ch_code(ch_code), .com_code(com_code), .pos_sel(pos_sel), .neg_sel(neg_sel));
  sam_link_monitor u_sam_link_monitor (.clk(clk), .srst(srst), .cs_n(link.cs_n),
    .sclk(link.sclk), .serial_address_in(link.serial_address_in), .dout(link.dout),
    .dout_oe_n(link.dout_oe_n), .conversion_active_flag(link.conversion_active_flag),
    .lsb_order_enable_n(link.lsb_order_enable_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer, c marks a checked read
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic c);
    rd_chk = c;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdx(input logic [31:0] a, input logic [2:0] k, input logic [31:0] v);
    note_q.push_back('{k, v});
    apb(1'b0, a, 32'h0, 1'b1);
  endtask

  // one conversion; abort resets mid-conversion
  task automatic convert(input logic [3:0] cfg, input logic abort);
    int         p;
    int         n;
    logic [7:0] pv;
    logic [7:0] nv;
    logic [7:0] code;
    logic [7:0] rev;
    p = 2 * cfg[1:0] + cfg[2];
    n = cfg[3] ? 8 : 2 * cfg[1:0] + !cfg[2];
    pv = ch_code[8*p +: 8];
    nv = cfg[3] ? com_code : ch_code[8*n +: 8];
    code = (pv > nv) ? pv - nv : 8'h00;
    rev = {<<{code}};
    apb(1'b1, `SAM_OFS_CFG, {27'h0, 1'b1, cfg}, 1'b0);
    rdx(`SAM_OFS_CFG, 3'd1, {27'h0, 1'b1, cfg});
    if (!abort)
      note_q.push_back('{3'd4, {15'h0, 8'h01 << p, 9'h001 << n}});
    apb(1'b1, `SAM_OFS_CTRL, 32'h1, 1'b0);
    if (abort)
    begin
      wait (link.conversion_active_flag === 1'b1);
      repeat (1000) @(posedge clk);
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rdx(`SAM_OFS_STATUS, 3'd1, 32'h0);
    end
    else
    begin
      rd = 32'h0;
      while (rd[1] !== 1'b1)
        apb(1'b0, `SAM_OFS_STATUS, 32'h0, 1'b0);
      rdx(`SAM_OFS_STATUS, 3'd1, 32'h2);
      apb(1'b1, `SAM_OFS_STATUS, 32'h2, 1'b0);
      rdx(`SAM_OFS_STATUS, 3'd1, 32'h0);
      rdx(`SAM_OFS_RESULT, 3'd2, {15'h0, 1'b0, code, rev});
    end
  endtask

  // result watcher
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite && rd_chk && note_q.size() > 0)
    begin
      nt = note_q.pop_front();
      case (nt.kind)
        3'd1: check(prdata, nt.val);
        3'd2: check(prdata, nt.val);
        default: check({31'h0, pslverr}, nt.val);
      endcase
    end
    if (busy_d && !link.conversion_active_flag && !srst && note_q.size() > 0)
    begin
      nt = note_q.pop_front();
      check({15'h0, pos_sel, neg_sel}, nt.val);
    end
    busy_d <= link.conversion_active_flag;
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    {psel, penable, pwrite, rd_chk, busy_d} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    ch_code = 64'h0;
    com_code = 8'h00;
    srst = 1'b1;
    void'($urandom(32'h85b6fa8a));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdx(`SAM_OFS_STATUS, 3'd1, 32'h0);
    rdx(32'h0000_0010, 3'd3, 32'h1);
    $display("test reset values done");
    for (int i = 0; i < 6; i++)
    begin
      ch_code <= {$urandom, $urandom};
      com_code <= (i == 0) ? 8'hff : 8'($urandom);
      @(posedge clk);
      convert((i < 5) ? tbl[i] : 4'($urandom), i == 4);
      $display("test conversion %0d done", i);
    end
    conclude();
  end
endmodule // serial_adc_mux_control_test
